// >>> core/rivm_pkg.sv
package rivm_pkg;
  localparam int ADDR_W = 16;
  localparam int NUM_IRQ = 34;
  localparam int IDX_W = 6;
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [15:0] TABLE_BASE = 16'h0000;
  localparam logic [15:0] BOOT_BASE_DEF = 16'hF000;
  localparam logic [5:0] LEGACY_FIRST = 6'h17;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_UNLOCK_BIT = 0;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  typedef enum logic [1:0] {RIVM_IDLE = 2'b00, RIVM_RESET = 2'b01, RIVM_IRQ = 2'b10} rivm_state_t;
endpackage : rivm_pkg

// >>> core/rivm_encoder.sv
module rivm_encoder
#(
  parameter int N = 34
)(
  input  wire logic [N-1:0] req,
  input  wire logic         legacy_mode,
  output logic              any,
  output logic [5:0]        idx
);
  import rivm_pkg::*;

  logic [N-1:0] live;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_gate
      // upper sources vanish in legacy mode
      assign live[g] = req[g] & ~(legacy_mode & (g >= int'(LEGACY_FIRST)));
    end
  endgenerate
  // lowest vector number wins
  always_comb
  begin
    any = 1'b0;
    idx = 6'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (live[i])
      begin
        any = 1'b1;
        idx = 6'(i);
      end
    end
  end
endmodule : rivm_encoder

// >>> core/rivm_vector_map.sv
// Notes on behaviour
// - unprogrammed boot select resets to zero
// - external requests 0..7 at 0002..0010
// - timer2, timer1, timer0 vectors 0012..0020
// - serial, converter, eeprom, comparator at 0022..002E
// - upper sources placed 0030..0044
// - programmed boot select resets to boot address
// - base select moves table to boot start
// - legacy mode removes upper vectors
// - reset and table selects independent
// - fuse one unprogrammed, zero programmed
// - control bits 1 and 0, reset zero
module rivm_vector_map
#(
  parameter int N = rivm_pkg::NUM_IRQ
)(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         boot_reset_select,
  input  wire logic         legacy_mode,
  input  wire logic [15:0]  boot_base,
  input  wire logic         reset_event,
  input  wire logic [N-1:0] irq_req,
  input  wire logic         ctrl_wr,
  input  wire logic [7:0]   ctrl_wdata,
  output logic [7:0]        mcu_control_reg,
  output logic              vector_valid,
  output logic              vector_is_reset,
  output logic [15:0]       vector_addr,
  output logic [5:0]        vector_num
);
  import rivm_pkg::*;

  logic [7:0]  ctrl_ff;
  logic [2:0]  unlock_cnt_ff;
  logic        any_irq;
  logic [5:0]  irq_idx;
  logic [15:0] reset_target;
  logic [15:0] table_base;
  logic [15:0] irq_target;
  logic        sel_wr_ok;
  logic [7:0]  nxt_ctrl;
  logic [2:0]  nxt_unlock_cnt;
  rivm_state_t state_ff;
  rivm_state_t nxt_state;
  logic        valid_ff;
  logic        is_reset_ff;
  logic [15:0] addr_ff;
  logic [5:0]  num_ff;
  logic        boot_pend_ff;
  logic        reset_req;

  rivm_encoder #(.N(N)) u_enc (
    .req         (irq_req),
    .legacy_mode (legacy_mode),
    .any         (any_irq),
    .idx         (irq_idx)
  );

  // power-up reset dispatches too, not only a reset_event
  assign reset_req = reset_event | boot_pend_ff;

  // reset target and table base chosen separately
  assign reset_target = boot_reset_select ? RESET_VEC : boot_base;
  assign table_base   = ctrl_ff[CTRL_SEL_BIT] ? boot_base : TABLE_BASE;
  // entry spans two words; source k sits at table + 2*(k+1)
  assign irq_target   = table_base + {9'h000, irq_idx + 6'h01, 1'b0};

  // select bit only changes inside the unlock window, with unlock clear in the same write
  assign sel_wr_ok = (unlock_cnt_ff != 3'h0) & ~ctrl_wdata[CTRL_UNLOCK_BIT];

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_unlock_cnt = (unlock_cnt_ff != 3'h0) ? unlock_cnt_ff - 3'h1 : 3'h0;
    if (ctrl_wr)
    begin
      nxt_ctrl[7:2] = ctrl_wdata[7:2];
      if (sel_wr_ok)
      begin
        nxt_ctrl[CTRL_SEL_BIT] = ctrl_wdata[CTRL_SEL_BIT];
        nxt_unlock_cnt = 3'h0;
      end
      else if (ctrl_wdata[CTRL_UNLOCK_BIT])
      begin
        nxt_unlock_cnt = UNLOCK_CYCLES;
      end
    end
    nxt_ctrl[CTRL_UNLOCK_BIT] = (nxt_unlock_cnt != 3'h0);
  end

  // reset has priority over any pending source
  always_comb
  begin
    case (state_ff)
      RIVM_IDLE:  nxt_state = reset_req ? RIVM_RESET : (any_irq ? RIVM_IRQ : RIVM_IDLE);
      RIVM_RESET: nxt_state = RIVM_IDLE;
      RIVM_IRQ:   nxt_state = RIVM_IDLE;
      default:    nxt_state = RIVM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_ff       <= CTRL_RST;
      unlock_cnt_ff <= 3'h0;
      state_ff      <= RIVM_IDLE;
      boot_pend_ff  <= 1'b1;
      valid_ff      <= 1'b0;
      is_reset_ff   <= 1'b0;
      addr_ff       <= 16'h0000;
      num_ff        <= 6'h00;
    end
    else
    begin
      ctrl_ff       <= nxt_ctrl;
      unlock_cnt_ff <= nxt_unlock_cnt;
      state_ff      <= nxt_state;
      boot_pend_ff  <= 1'b0;
      valid_ff      <= (nxt_state != RIVM_IDLE);
      is_reset_ff   <= (nxt_state == RIVM_RESET);
      if (nxt_state == RIVM_RESET)
      begin
        addr_ff <= reset_target;
        num_ff  <= 6'h00;
      end
      else if (nxt_state == RIVM_IRQ)
      begin
        addr_ff <= irq_target;
        num_ff  <= irq_idx + 6'h01;
      end
    end
  end

  assign mcu_control_reg = ctrl_ff;
  assign vector_valid    = valid_ff;
  assign vector_is_reset = is_reset_ff;
  assign vector_addr     = addr_ff;
  assign vector_num      = num_ff;

  // $past: the outputs carry the levels seen at the dispatch edge
  property p_reset_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      (vector_valid && vector_is_reset) |-> vector_addr == ($past(boot_reset_select) ? 16'h0000 : $past(boot_base));
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("reset vector wrong");

  property p_irq_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      (vector_valid && !vector_is_reset) |->
        vector_addr == ($past(ctrl_ff[1]) ? $past(boot_base) : 16'h0000) + {9'h000, vector_num, 1'b0};
  endproperty
  a_irq_addr: assert property (p_irq_addr) else $error("irq vector wrong");

  property p_ext0;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_ff == RIVM_IDLE && !reset_req && irq_req[0] && !ctrl_ff[1]) |=> vector_addr == 16'h0002;
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext0 not at 0002");

  property p_ext7;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_ff == RIVM_IDLE && !reset_req && irq_req[7:0] == 8'h80 && !ctrl_ff[1]) |=> vector_addr == 16'h0010;
  endproperty
  a_ext7: assert property (p_ext7) else $error("ext7 not at 0010");

  property p_range;
    @(posedge clk_sys) disable iff (!rst_n)
      (vector_valid && !vector_is_reset && !$past(ctrl_ff[1])) |-> vector_addr >= 16'h0002 && vector_addr <= 16'h0044;
  endproperty
  a_range: assert property (p_range) else $error("vector out of table");

  property p_legacy;
    @(posedge clk_sys) disable iff (!rst_n)
      (vector_valid && !vector_is_reset && $past(legacy_mode)) |-> vector_num < 6'h18;
  endproperty
  a_legacy: assert property (p_legacy) else $error("upper vector in legacy mode");

  property p_legacy_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_ff == RIVM_IDLE && !reset_req && legacy_mode && irq_req[22:0] == 23'h00_0000) |=> !vector_valid;
  endproperty
  a_legacy_quiet: assert property (p_legacy_quiet) else $error("masked source dispatched");

  property p_reset_prio;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_ff == RIVM_IDLE && reset_req) |=> vector_valid && vector_is_reset;
  endproperty
  a_reset_prio: assert property (p_reset_prio) else $error("reset not dispatched");

  property p_sel_locked;
    @(posedge clk_sys) disable iff (!rst_n)
      (unlock_cnt_ff == 3'h0) |=> $stable(ctrl_ff[1]);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("select changed while locked");

  property p_unlock_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(ctrl_ff[0]) ##0 (!ctrl_wr) [*4] |=> !ctrl_ff[0];
  endproperty
  a_unlock_clears: assert property (p_unlock_clears) else $error("unlock did not expire");

  property p_unlock_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrl_wr && ctrl_wdata[CTRL_UNLOCK_BIT]) |=> mcu_control_reg[CTRL_UNLOCK_BIT];
  endproperty
  a_unlock_set: assert property (p_unlock_set) else $error("unlock bit not set");

  property p_after_reset;
    @(posedge clk_sys) $rose(rst_n) |-> ctrl_ff[1:0] == 2'b00 ##1 vector_valid && vector_is_reset;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("reset state wrong");

  c_boot_reset: cover property (@(posedge clk_sys) vector_is_reset && !boot_reset_select);
  c_boot_table: cover property (@(posedge clk_sys) vector_valid && !vector_is_reset && ctrl_ff[1]);
  c_legacy:     cover property (@(posedge clk_sys) legacy_mode && irq_req[33]);
  c_unlock_lapse: cover property (@(posedge clk_sys) $fell(ctrl_ff[0]) && !ctrl_wr);
  c_legacy_masked: cover property (@(posedge clk_sys) legacy_mode && irq_req[23] && !vector_valid);
endmodule : rivm_vector_map

// >>> bench/rivm_cpu_model.sv
module rivm_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        vector_valid,
  input  wire logic [15:0] vector_addr,
  input  wire logic        set_go,
  input  wire logic        set_val,
  input  wire logic        set_late,
  output logic             ctrl_wr,
  output logic [7:0]       ctrl_wdata,
  output logic [15:0]      fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_ff = 3'h0;
  initial ctrl_wr = 1'b0;
  initial ctrl_wdata = 8'h00;
  // unlock write, then the select write one cycle later, or six cycles later to miss the window
  always @(negedge clk_sys)
  begin
    ctrl_wr <= set_go | (wait_ff == 3'h1);
    ctrl_wdata <= set_go ? 8'h01 : (wait_ff == 3'h1) ? {6'h00, set_val, 1'b0} : ~ctrl_wdata;
    wait_ff <= set_go ? (set_late ? 3'h6 : 3'h1) : (wait_ff != 3'h0) ? wait_ff - 3'h1 : 3'h0;
  end
  always @(posedge clk_sys)
    if (vector_valid === 1'b1) fetch_addr <= vector_addr;
endmodule : rivm_cpu_model

// >>> bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rivm_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        boot_reset_select = 1'b1;
  logic        legacy_mode = 1'b0;
  logic [15:0] boot_base = 16'hE000;
  logic        reset_event = 1'b0;
  logic [33:0] irq_req = '0;
  logic        ctrl_wr, vector_valid, vector_is_reset, set_go = 1'b0, set_val = 1'b0, set_late = 1'b0, seen;
  logic [7:0]  ctrl_wdata, mcu_control_reg;
  logic [15:0] vector_addr, fetch_addr;
  logic [5:0]  vector_num;
  int          failures = 0;
  int          total_checks = 0;
  rivm_vector_map rivm_vector_map_i (.clk_sys, .rst_n, .boot_reset_select, .legacy_mode, .boot_base,
    .reset_event, .irq_req, .ctrl_wr, .ctrl_wdata, .mcu_control_reg, .vector_valid, .vector_is_reset,
    .vector_addr, .vector_num);
  rivm_cpu_model rivm_cpu_model_i (.clk_sys, .vector_valid, .vector_addr, .set_go, .set_val, .set_late, .ctrl_wr,
    .ctrl_wdata, .fetch_addr);
  always #25 clk_sys = ~clk_sys;
  task report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait: a missing dispatch shows as seen low, not as a hang
  task wait_vec;
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++)
    begin
      @(posedge clk_sys);
      #1;
      seen = (vector_valid === 1'b1);
    end
  endtask : wait_vec
  task chk_reset;
    wait_vec();
    chk(seen, 1'b1);
    chk(vector_is_reset, 1'b1);
    chk(vector_addr, boot_reset_select ? 16'h0000 : boot_base);
  endtask : chk_reset
  task irq(input int k, input logic exp_seen, input logic [15:0] base);
    @(negedge clk_sys);
    irq_req <= 34'h0_0000_0001 << k;
    wait_vec();
    @(negedge clk_sys);
    irq_req <= '0;
    chk(seen, exp_seen);
    if (exp_seen)
    begin
      chk(vector_addr, base + 16'((k + 1) * 2));
      chk(vector_num, 16'(k + 1));
      @(posedge clk_sys);
      #1;
      chk(fetch_addr, base + 16'((k + 1) * 2));
    end
  endtask : irq
  initial
  begin
    #500000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    for (int c = 0; c < 4; c++)
    begin
      @(negedge clk_sys);
      rst_n <= 1'b0;
      boot_reset_select <= c[1];
      repeat (12) @(negedge clk_sys);
      rst_n <= 1'b1;
      chk_reset();
      chk(mcu_control_reg, 16'h0000);
      @(negedge clk_sys);
      set_val <= c[0];
      set_go <= 1'b1;
      @(negedge clk_sys);
      set_go <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(mcu_control_reg[1], c[0]);
      reset_event <= 1'b1;
      chk_reset();
      @(negedge clk_sys);
      reset_event <= 1'b0;
      for (int k = 0; k < NUM_IRQ; k++)
        irq(k, 1'b1, c[0] ? boot_base : 16'h0000);
    end
    @(negedge clk_sys);
    legacy_mode <= 1'b1;
    irq(22, 1'b1, boot_base);
    irq(23, 1'b0, boot_base);
    irq(33, 1'b0, boot_base);
    // select write after the unlock window has lapsed must be refused
    @(negedge clk_sys);
    set_val <= 1'b0;
    set_late <= 1'b1;
    set_go <= 1'b1;
    @(negedge clk_sys);
    set_go <= 1'b0;
    repeat (10) @(negedge clk_sys);
    chk(mcu_control_reg, 16'h0002);
    report_and_stop();
  end
endmodule : tb
